// [lsa_top.sv]
// list address pointers with apb register access and fetch/store address generation
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - A 6-bit command index counts 32-bit commands from the active list start, readable but never writable.
// - The command base pointer bits 23:2 hold the command list base and are writable only when disabled or in special access.
// - Each command fetch address uses the base pointer plus the offset of the active command list.
// - A 6-bit result index counts 16-bit results, is read-only and is advanced by the converter.
// - The result base pointer bits 19:2 give the base of the result lists in system RAM.
// - Writes to the result base pointer take effect only when disabled or in special access, else it holds.
// - Offset zero is a fixed read-only zero selecting the first lists.
// - Offsets count objects: 16-bit for results and 32-bit for commands.
// - Offset one is a 7-bit offset for the second lists, writable only when disabled or in special access.
// - Each address picks its own offset: the result store by the result list select, the command load by the command list select.
// - Addresses are base plus selected offset plus index, for commands and for results.
// - A status bit shows the active command list and so which offset is applied.
// - An access outside the allowed memory sets the illegal access flag and an interrupt if enabled.
module lsa_top
	import lsa_pkg::*;
(
	// clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// apb slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic                    pready,
	output logic [31:0]             prdata,
	output logic                    pslverr,
	// converter side
	input  wire logic               cmd_fetch_req,
	input  wire logic               res_store_req,
	input  wire logic               cmd_index_clr,
	input  wire logic               res_index_clr,
	input  wire logic               cmd_list_swap,
	input  wire logic               res_list_swap,
	output logic                    converter_enable,
	output logic                    cmd_fetch_vld,
	output logic [CMD_AW-1:0]       cmd_fetch_addr,
	output logic                    res_store_vld,
	output logic [RES_AW-1:0]       res_store_addr,
	// interrupt
	output logic                    irq
);

	// ==========================================================
	// registers
	lsa_ctrl_t              ctrl_ff;
	logic [7:0]             byte3_ff;
	logic [CMD_AW-1:0]      cbase_ff;
	logic [RES_AW-1:0]      rbase_ff;
	logic [OFF_W-1:0]       off1_ff;
	logic                   csel_ff;
	logic                   rsel_ff;
	logic [IRQ_W-1:0]       irq_stat_ff;
	logic [IRQ_W-1:0]       irq_mask_ff;
	logic                   pready_ff;
	logic [31:0]            prdata_ff;
	logic                   pslverr_ff;
	logic                   irq_ff;
	lsa_acc_t               cmd_acc_ff;
	lsa_acc_t               res_acc_ff;

	// ==========================================================
	// bus decode
	logic [7:0]             reg_idx;
	logic                   acc_go;
	logic                   wr_go;
	logic                   ptr_wr_ok;
	logic                   mapped;
	logic [31:0]            nxt_prdata;
	logic [IDX_W-1:0]       cmd_index_cur;
	logic [IDX_W-1:0]       res_index_cur;
	logic [OFF_W-1:0]       cmd_off;
	logic [OFF_W-1:0]       res_off;
	logic [CMD_AW-1:0]      cmd_addr;
	logic [RES_AW-1:0]      res_addr;
	logic                   cmd_out;
	logic                   res_out;
	logic                   cmd_go;
	logic                   res_go;
	logic [IRQ_W-1:0]       irq_set;

	assign reg_idx   = paddr[9:2];
	assign acc_go    = psel && penable && pready_ff;
	assign wr_go     = acc_go && pwrite && mapped;
	assign ptr_wr_ok = !ctrl_ff.converter_enable || ctrl_ff.special_access;

	always_comb begin
		mapped = 1'b1;
		nxt_prdata = 32'h00000000;
		case (reg_idx)
			IDX_CMD_BYTE3: nxt_prdata[7:0] = byte3_ff;
			IDX_CMD_INDEX: nxt_prdata[IDX_W-1:0] = cmd_index_cur;
			IDX_CMD_BASE:  nxt_prdata[CMD_AW-1:0] = cbase_ff;
			IDX_RES_INDEX: nxt_prdata[IDX_W-1:0] = res_index_cur;
			IDX_RES_BASE:  nxt_prdata[RES_AW-1:0] = rbase_ff;
			IDX_OFF_ZERO:  nxt_prdata[OFF_W-1:0] = OFF_ZERO;
			IDX_OFF_ONE:   nxt_prdata[OFF_W-1:0] = off1_ff;
			IDX_CTRL: begin
				nxt_prdata[CTRL_EN]   = ctrl_ff.converter_enable;
				nxt_prdata[CTRL_SACC] = ctrl_ff.special_access;
			end
			IDX_STATUS: begin
				nxt_prdata[STAT_CSEL] = csel_ff;
				nxt_prdata[STAT_RSEL] = rsel_ff;
			end
			IDX_IRQ_STAT:  nxt_prdata[IRQ_W-1:0] = irq_stat_ff;
			IDX_IRQ_MASK:  nxt_prdata[IRQ_W-1:0] = irq_mask_ff;
			default:       mapped = 1'b0;
		endcase
		if (paddr[11:10] != 2'b00 || paddr[1:0] != 2'b00) begin
			mapped = 1'b0;
			nxt_prdata = 32'h00000000;
		end
	end

	// ==========================================================
	// apb handshake: one wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			prdata_ff  <= 32'h00000000;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff  <= psel && penable && !pready_ff;
			pslverr_ff <= psel && penable && !pready_ff && !mapped;
			if (psel && penable && !pready_ff && !pwrite) begin
				prdata_ff <= nxt_prdata;
			end else begin
				prdata_ff <= 32'h00000000;
			end
		end
	end

	// ==========================================================
	// control and command byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff  <= '0;
			byte3_ff <= RST_BYTE3;
		end else if (wr_go) begin
			if (reg_idx == IDX_CTRL) begin
				ctrl_ff.converter_enable <= pwdata[CTRL_EN];
				ctrl_ff.special_access   <= pwdata[CTRL_SACC];
			end
			if (reg_idx == IDX_CMD_BYTE3) begin
				byte3_ff <= pwdata[7:0];
			end
		end
	end

	// ==========================================================
	// base pointers and offset one, write gated by enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cbase_ff <= RST_CBASE;
			rbase_ff <= RST_RBASE;
			off1_ff  <= RST_OFF1;
		end else if (wr_go && ptr_wr_ok) begin
			if (reg_idx == IDX_CMD_BASE) begin
				cbase_ff <= {pwdata[CMD_AW-1:PTR_LSB], 2'b00};
			end
			if (reg_idx == IDX_RES_BASE) begin
				rbase_ff <= {pwdata[RES_AW-1:PTR_LSB], 2'b00};
			end
			if (reg_idx == IDX_OFF_ONE) begin
				off1_ff <= pwdata[OFF_W-1:0];
			end
		end
	end

	// ==========================================================
	// active list selects, swapped by the converter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			csel_ff <= 1'b0;
			rsel_ff <= 1'b0;
		end else if (ctrl_ff.converter_enable) begin
			if (cmd_list_swap) begin
				csel_ff <= !csel_ff;
			end
			if (res_list_swap) begin
				rsel_ff <= !rsel_ff;
			end
		end
	end

	// ==========================================================
	// indices
	assign cmd_go = ctrl_ff.converter_enable && cmd_fetch_req;
	assign res_go = ctrl_ff.converter_enable && res_store_req;

	lsa_index u_cmd_index (
		.pclk    (pclk),
		.presetn (presetn),
		.clr     (cmd_index_clr),
		.inc     (cmd_go && !cmd_out),
		.index   (cmd_index_cur)
	);

	lsa_index u_res_index (
		.pclk    (pclk),
		.presetn (presetn),
		.clr     (res_index_clr),
		.inc     (res_go && !res_out),
		.index   (res_index_cur)
	);

	// ==========================================================
	// address generation
	assign cmd_off = csel_ff ? off1_ff : OFF_ZERO;
	assign res_off = rsel_ff ? off1_ff : OFF_ZERO;

	lsa_addr_gen #(
		.AW    (CMD_AW),
		.SHIFT (CMD_SHIFT)
	) u_cmd_addr (
		.base    (cbase_ff),
		.offset  (cmd_off),
		.index   (cmd_index_cur),
		.lo_a    (RAM_LO),
		.hi_a    (RAM_HI),
		.lo_b    (NVM_LO),
		.hi_b    (NVM_HI),
		.addr    (cmd_addr),
		.outside (cmd_out)
	);

	lsa_addr_gen #(
		.AW    (RES_AW),
		.SHIFT (RES_SHIFT)
	) u_res_addr (
		.base    (rbase_ff),
		.offset  (res_off),
		.index   (res_index_cur),
		.lo_a    (RAM_LO[RES_AW-1:0]),
		.hi_a    (RAM_HI[RES_AW-1:0]),
		.lo_b    (RAM_LO[RES_AW-1:0]),
		.hi_b    (RAM_HI[RES_AW-1:0]),
		.addr    (res_addr),
		.outside (res_out)
	);

	// ==========================================================
	// access strobes toward the memory bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_acc_ff <= '0;
			res_acc_ff <= '0;
		end else begin
			cmd_acc_ff.vld <= cmd_go && !cmd_out;
			cmd_acc_ff.err <= cmd_go && cmd_out;
			res_acc_ff.vld <= res_go && !res_out;
			res_acc_ff.err <= res_go && res_out;
			if (cmd_go) begin
				cmd_acc_ff.addr <= cmd_addr;
			end
			if (res_go) begin
				res_acc_ff.addr <= {{(CMD_AW-RES_AW){1'b0}}, res_addr};
			end
		end
	end

	// ==========================================================
	// interrupt status, set wins over write-one clear
	assign irq_set[IRQ_IA]   = (cmd_go && cmd_out) || (res_go && res_out);
	assign irq_set[IRQ_SWAP] = ctrl_ff.converter_enable && cmd_list_swap;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_ff <= RST_IRQ;
			irq_mask_ff <= RST_IRQ;
		end else begin
			if (wr_go && reg_idx == IDX_IRQ_STAT) begin
				irq_stat_ff <= (irq_stat_ff & ~pwdata[IRQ_W-1:0]) | irq_set;
			end else begin
				irq_stat_ff <= irq_stat_ff | irq_set;
			end
			if (wr_go && reg_idx == IDX_IRQ_MASK) begin
				irq_mask_ff <= pwdata[IRQ_W-1:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(irq_stat_ff & irq_mask_ff);
		end
	end

	// ==========================================================
	// outputs
	assign pready           = pready_ff;
	assign prdata           = prdata_ff;
	assign pslverr          = pslverr_ff;
	assign converter_enable = ctrl_ff.converter_enable;
	assign cmd_fetch_vld    = cmd_acc_ff.vld;
	assign cmd_fetch_addr   = cmd_acc_ff.addr;
	assign res_store_vld    = res_acc_ff.vld;
	assign res_store_addr   = res_acc_ff.addr[RES_AW-1:0];
	assign irq              = irq_ff;

endmodule
`default_nettype wire

// [lsa_pkg.sv]
// package: register map, fields and limits of the list address pointer block
`default_nettype none
package lsa_pkg;

	// ==========================================================
	// register indices (byte address is four times the index)
	localparam logic [7:0] IDX_CMD_BYTE3 = 8'h17;
	localparam logic [7:0] IDX_CMD_INDEX = 8'h18;
	localparam logic [7:0] IDX_CMD_BASE  = 8'h19;
	localparam logic [7:0] IDX_RES_INDEX = 8'h20;
	localparam logic [7:0] IDX_RES_BASE  = 8'h21;
	localparam logic [7:0] IDX_OFF_ZERO  = 8'h22;
	localparam logic [7:0] IDX_OFF_ONE   = 8'h23;
	localparam logic [7:0] IDX_CTRL      = 8'h24;
	localparam logic [7:0] IDX_STATUS    = 8'h25;
	localparam logic [7:0] IDX_IRQ_STAT  = 8'h26;
	localparam logic [7:0] IDX_IRQ_MASK  = 8'h27;

	// ==========================================================
	// widths and field positions
	localparam int IDX_W      = 6;
	localparam int OFF_W      = 7;
	localparam int CMD_AW     = 24;
	localparam int RES_AW     = 20;
	localparam int PTR_LSB    = 2;
	localparam int CMD_SHIFT  = 2;
	localparam int RES_SHIFT  = 1;
	localparam int CTRL_EN    = 0;
	localparam int CTRL_SACC  = 1;
	localparam int STAT_CSEL  = 0;
	localparam int STAT_RSEL  = 1;
	localparam int IRQ_IA     = 0;
	localparam int IRQ_SWAP   = 1;
	localparam int IRQ_W      = 2;

	// ==========================================================
	// reset values
	localparam logic [7:0]        RST_BYTE3 = 8'h00;
	localparam logic [CMD_AW-1:0] RST_CBASE = 24'h000000;
	localparam logic [RES_AW-1:0] RST_RBASE = 20'h00000;
	localparam logic [OFF_W-1:0]  OFF_ZERO  = 7'h00;
	localparam logic [OFF_W-1:0]  RST_OFF1  = 7'h00;
	localparam logic [IRQ_W-1:0]  RST_IRQ   = 2'h0;

	// ==========================================================
	// memory windows (plain defaults)
	localparam logic [CMD_AW-1:0] RAM_LO = 24'h001000;
	localparam logic [CMD_AW-1:0] RAM_HI = 24'h001FFF;
	localparam logic [CMD_AW-1:0] NVM_LO = 24'hFC0000;
	localparam logic [CMD_AW-1:0] NVM_HI = 24'hFFFFFF;

	typedef struct packed {
		logic special_access;
		logic converter_enable;
	} lsa_ctrl_t;

	typedef struct packed {
		logic                   vld;
		logic                   err;
		logic [CMD_AW-1:0]      addr;
	} lsa_acc_t;

endpackage
`default_nettype wire

// [lsa_index.sv]
// list index counter advanced by the converter
`timescale 1ns/100ps
`default_nettype none
module lsa_index
	import lsa_pkg::*;
(
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// control
	input  wire logic             clr,
	input  wire logic             inc,
	// state
	output logic [IDX_W-1:0]      index
);

	logic [IDX_W-1:0] index_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			index_ff <= '0;
		end else if (clr) begin
			index_ff <= '0;
		end else if (inc) begin
			index_ff <= index_ff + 1'b1;
		end
	end

	assign index = index_ff;

endmodule
`default_nettype wire

// [lsa_addr_gen.sv]
// object address builder with memory window check
`timescale 1ns/100ps
`default_nettype none
module lsa_addr_gen
	import lsa_pkg::*;
#(
	parameter int AW    = 24,
	parameter int SHIFT = 2
) (
	// operands
	input  wire logic [AW-1:0]    base,
	input  wire logic [OFF_W-1:0] offset,
	input  wire logic [IDX_W-1:0] index,
	// windows
	input  wire logic [AW-1:0]    lo_a,
	input  wire logic [AW-1:0]    hi_a,
	input  wire logic [AW-1:0]    lo_b,
	input  wire logic [AW-1:0]    hi_b,
	// result
	output logic [AW-1:0]         addr,
	output logic                  outside
);

	logic [OFF_W:0] objects;
	logic [AW-1:0]  scaled;

	// objects scaled to bytes, base kept even
	assign objects = {1'b0, offset} + {2'b00, index};
	assign scaled  = AW'({objects, SHIFT'(0)});
	assign addr    = {base[AW-1:1], 1'b0} + scaled;
	assign outside = !((addr >= lo_a && addr <= hi_a) || (addr >= lo_b && addr <= hi_b));

endmodule
`default_nettype wire

// [lsa_asserts.sv]
// concurrent checks on the list address pointer ports
`timescale 1ns/100ps
`default_nettype none
module lsa_asserts
	import lsa_pkg::*;
(
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pready,
	input  wire logic              pslverr,
	input  wire logic [31:0]       prdata,
	// converter side
	input  wire logic              cmd_fetch_req,
	input  wire logic              res_store_req,
	input  wire logic              converter_enable,
	input  wire logic              cmd_fetch_vld,
	input  wire logic [CMD_AW-1:0] cmd_fetch_addr,
	input  wire logic              res_store_vld,
	input  wire logic [RES_AW-1:0] res_store_addr
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// apb
	sequence s_wait;
		psel && penable && !pready;
	endsequence
	chk_apb_one_wait: assert property (s_wait |=> pready && psel && penable)
		else $error("ready missing after one wait state");
	chk_ready_in_access: assert property (pready |-> psel && penable)
		else $error("ready outside access phase");
	chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data not zero while idle");
	chk_err_with_ready: assert property (pslverr |-> pready)
		else $error("slave error without ready");
	// ==========================================================
	// address generation
	chk_fetch_cause: assert property (cmd_fetch_vld |-> $past(cmd_fetch_req) && $past(converter_enable))
		else $error("fetch valid without enabled request");
	chk_store_cause: assert property (res_store_vld |-> $past(res_store_req) && $past(converter_enable))
		else $error("store valid without enabled request");
	chk_cmd_aligned: assert property (cmd_fetch_vld |-> cmd_fetch_addr[1:0] == 2'h0)
		else $error("fetch address not word aligned");
	chk_res_aligned: assert property (res_store_vld |-> res_store_addr[0] == 1'b0)
		else $error("store address not half aligned");
	chk_cmd_addr_hold: assert property (!cmd_fetch_req |=> $stable(cmd_fetch_addr))
		else $error("fetch address moved without request");
	chk_res_addr_hold: assert property (!res_store_req |=> $stable(res_store_addr))
		else $error("store address moved without request");
endmodule
`default_nettype wire

// [lsa_mem_model.sv]
// memory side model logging fetch and store addresses
`timescale 1ns/100ps
`default_nettype none
module lsa_mem_model
	import lsa_pkg::*;
(
	// clock
	input  wire logic              pclk,
	// address traffic
	input  wire logic              cmd_vld,
	input  wire logic [CMD_AW-1:0] cmd_addr,
	input  wire logic              res_vld,
	input  wire logic [RES_AW-1:0] res_addr,
	// log
	output logic [7:0]             cmd_cnt = 8'h00,
	output logic [CMD_AW-1:0]      cmd_last = 24'h000000,
	output logic [7:0]             res_cnt = 8'h00,
	output logic [RES_AW-1:0]      res_last = 20'h00000
);
	always @(posedge pclk) begin
		if (cmd_vld === 1'b1) begin
			cmd_cnt <= cmd_cnt + 8'h01;
			cmd_last <= cmd_addr;
		end
		if (res_vld === 1'b1) begin
			res_cnt <= res_cnt + 8'h01;
			res_last <= res_addr;
		end
	end
endmodule
`default_nettype wire

// [tb_adc_list_address_pointers.sv]
// self-checking bench for the list address pointer block
`timescale 1ns/100ps
`default_nettype none
module tb_adc_list_address_pointers
	import lsa_pkg::*;
;
	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [11:0]       paddr = 12'h000;
	logic [31:0]       pwdata = 32'h0;
	logic [5:0]        cv = 6'h00;
	wire               pready, pslverr, converter_enable, irq;
	wire               cmd_fetch_req, res_store_req, cmd_index_clr, res_index_clr;
	wire               cmd_list_swap, res_list_swap, cmd_fetch_vld, res_store_vld;
	wire [31:0]        prdata;
	wire [CMD_AW-1:0]  cmd_fetch_addr, cmd_last;
	wire [RES_AW-1:0]  res_store_addr, res_last;
	wire [7:0]         cmd_cnt, res_cnt;
	int                err_total = 0;
	int                total_checks = 0;
	localparam logic [5:0] C_FETCH = 6'h20, R_STORE = 6'h10, C_CLR = 6'h08;
	localparam logic [5:0] R_CLR = 6'h04, C_SWAP = 6'h02, R_SWAP = 6'h01;
	assign {cmd_fetch_req, res_store_req, cmd_index_clr, res_index_clr, cmd_list_swap,
		res_list_swap} = cv;
	always #10 pclk = ~pclk;
	lsa_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .cmd_fetch_req(cmd_fetch_req), .res_store_req(res_store_req),
		.cmd_index_clr(cmd_index_clr), .res_index_clr(res_index_clr),
		.cmd_list_swap(cmd_list_swap),
		.res_list_swap(res_list_swap), .converter_enable(converter_enable),
		.cmd_fetch_vld(cmd_fetch_vld), .cmd_fetch_addr(cmd_fetch_addr),
		.res_store_vld(res_store_vld), .res_store_addr(res_store_addr), .irq(irq));
	lsa_mem_model mem_u (.pclk(pclk), .cmd_vld(cmd_fetch_vld), .cmd_addr(cmd_fetch_addr),
		.res_vld(res_store_vld), .res_addr(res_store_addr), .cmd_cnt(cmd_cnt),
		.cmd_last(cmd_last), .res_cnt(res_cnt), .res_last(res_last));
	// ==========================================================
	// bus and check helpers
	task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
		total_checks++;
		if (g !== x) begin
			$display("mismatch %s exp %h got %h", s, x, g);
			err_total++;
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, i, 2'h0};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) chk("pready", 32'h1, 32'h0);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, i, d, r, e);
	endtask
	task automatic rd(input logic [7:0] i, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, i, 32'h0, r, e);
		chk($sformatf("reg %h", i), x, r);
	endtask
	task automatic conv(input logic [5:0] v, input int n);
		@(posedge pclk);
		cv <= v;
		repeat (n) @(posedge pclk);
		cv <= 6'h00;
		repeat (3) @(posedge pclk);
	endtask
	// ==========================================================
	// scenarios
	task automatic t_reset();
		logic [7:0] rz [8] = '{IDX_CMD_INDEX, IDX_CMD_BASE, IDX_RES_INDEX, IDX_RES_BASE,
			IDX_OFF_ZERO, IDX_OFF_ONE, IDX_STATUS, IDX_IRQ_STAT};
		logic [31:0] r;
		logic e;
		foreach (rz[k]) rd(rz[k], 32'h0);
		apb(1'b0, 8'h30, 32'h0, r, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		conv(C_FETCH | R_STORE, 1);
		chk("disabled fetch", 32'h0, {24'h0, cmd_cnt});
		$display("test reset done");
	endtask
	task automatic t_regs();
		logic [7:0] ri [6] = '{IDX_CMD_BASE, IDX_RES_BASE, IDX_OFF_ONE, IDX_OFF_ZERO,
			IDX_CMD_INDEX, IDX_RES_INDEX};
		logic [31:0] rx [6] = '{32'h00FFFFFC, 32'h000FFFFC, 32'h7F, 32'h0, 32'h0, 32'h0};
		foreach (ri[k]) wr(ri[k], 32'hFFFFFFFF);
		foreach (ri[k]) rd(ri[k], rx[k]);
		wr(IDX_CMD_BASE, 32'h00001000);
		wr(IDX_RES_BASE, 32'h00001100);
		wr(IDX_OFF_ONE, 32'h00000005);
		$display("test registers done");
	endtask
	task automatic t_lock();
		wr(IDX_CTRL, 32'h1);
		@(posedge pclk);
		chk("enable", 32'h1, {31'h0, converter_enable});
		wr(IDX_CMD_BASE, 32'h00002000);
		wr(IDX_RES_BASE, 32'h00002000);
		wr(IDX_OFF_ONE, 32'h00000007);
		rd(IDX_CMD_BASE, 32'h00001000);
		rd(IDX_RES_BASE, 32'h00001100);
		rd(IDX_OFF_ONE, 32'h00000005);
		wr(IDX_CTRL, 32'h3);
		wr(IDX_OFF_ONE, 32'h00000006);
		rd(IDX_OFF_ONE, 32'h00000006);
		wr(IDX_CTRL, 32'h1);
		$display("test lock done");
	endtask
	task automatic t_fetch();
		conv(C_FETCH, 3);
		chk("fetch count", 32'h3, {24'h0, cmd_cnt});
		chk("fetch addr", 32'h1000 + 2 * 4, {8'h0, cmd_last});
		rd(IDX_CMD_INDEX, 32'h3);
		conv(R_STORE, 2);
		chk("store count", 32'h2, {24'h0, res_cnt});
		chk("store addr", 32'h1100 + 1 * 2, {12'h0, res_last});
		rd(IDX_RES_INDEX, 32'h2);
		$display("test fetch done");
	endtask
	task automatic t_swap();
		conv(C_SWAP | R_SWAP, 1);
		rd(IDX_STATUS, 32'h3);
		conv(C_CLR | R_CLR, 1);
		rd(IDX_CMD_INDEX, 32'h0);
		conv(C_FETCH | R_STORE, 1);
		chk("fetch addr list one", 32'h1000 + 6 * 4, {8'h0, cmd_last});
		chk("store addr list one", 32'h1100 + 6 * 2, {12'h0, res_last});
		$display("test swap done");
	endtask
	task automatic t_irq();
		wr(IDX_IRQ_STAT, 32'h3);
		wr(IDX_IRQ_MASK, 32'h1);
		wr(IDX_CTRL, 32'h3);
		wr(IDX_CMD_BASE, 32'h00002000);
		wr(IDX_CTRL, 32'h1);
		conv(C_FETCH, 1);
		chk("no fetch outside", 32'h4, {24'h0, cmd_cnt});
		rd(IDX_CMD_INDEX, 32'h1);
		rd(IDX_IRQ_STAT, 32'h1);
		chk("irq raised", 32'h1, {31'h0, irq});
		wr(IDX_IRQ_MASK, 32'h0);
		repeat (2) @(posedge pclk);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(IDX_IRQ_STAT, 32'h1);
		rd(IDX_IRQ_STAT, 32'h0);
		$display("test irq done");
	endtask
	task automatic t_rerst();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("enable in reset", 32'h0, {31'h0, converter_enable});
		presetn <= 1'b1;
		rd(IDX_CTRL, 32'h0);
		rd(IDX_CMD_BASE, 32'h0);
		rd(IDX_OFF_ONE, 32'h0);
		rd(IDX_CMD_INDEX, 32'h0);
		$display("test reset again done");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_regs();
		t_lock();
		t_fetch();
		t_swap();
		t_irq();
		t_rerst();
		tally_and_finish();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		err_total++;
		tally_and_finish();
	end
endmodule
bind lsa_top lsa_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
	.cmd_fetch_req(cmd_fetch_req), .res_store_req(res_store_req),
	.converter_enable(converter_enable), .cmd_fetch_vld(cmd_fetch_vld),
	.cmd_fetch_addr(cmd_fetch_addr), .res_store_vld(res_store_vld),
	.res_store_addr(res_store_addr));
`default_nettype wire
